// >>> src/twx_core.sv
// Execution of table write, test-and-skip-if-zero and xor-literal instructions.
`timescale 1ns/100ps
`include "twx_params.svh"
// Contract
// RULE1: The table pointer is 21 bits wide, covering a 2-megabyte program space.
// RULE2: Pointer bit 0 picks the low byte when 0 and the high byte when 1.
// RULE3: Table write leaves the pointer, post-increments, post-decrements or pre-increments it.
// RULE4: Table write is 0000 0000 0000 11nn with nn choosing the pointer treatment 0 to 3.
// RULE5: Table write takes two cycles, reading the latch in Q2 and writing the holder in Q4.
// RULE6: A test-skip on a zero register flushes the fetched word and runs a no-operation.
// RULE7: If the skipped instruction is two words, two no-operation cycles are spent.
// RULE8: Test-skip is 0110 011a ffff ffff and alters no flags.
// RULE9: Access bit 0 uses the access bank, bit 1 uses the bank select register.
// RULE10: Access bit 0, extended set on and operand up to 95 selects indexed literal offset mode.
// RULE11: A non-skipping test-skip reads and evaluates the register with no write-back.
// RULE12: Xor-literal xors the working register with the literal and updates negative and zero.
// RULE13: Xor-literal is 0000 1010 kkkk kkkk.
// RULE14: Xor-literal is one word, one cycle, writing the working register in Q4.
module twx_core (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [1:0] i_qphase,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic i_next_two_word,
   input wire logic i_ext_enable,
   input wire logic [3:0] i_bank_select,
   input wire logic [7:0] i_file_data,
   input wire logic [7:0] i_table_latch,
   output twx_pkg::twx_faddr_t o_file_addr,
   output logic o_file_read,
   output logic o_fetch_hold,
   output logic o_flush,
   output logic o_busy,
   output logic [20:0] o_table_pointer,
   output logic o_hold_we,
   output logic o_hold_byte_high,
   output logic [20:0] o_hold_addr,
   output logic [7:0] o_hold_data,
   output logic [7:0] o_working_reg,
   output logic o_negative_flag,
   output logic o_zero_flag
);
   import twx_pkg::*;

   // ----------------------------------------
   // Decode and operand addressing
   // ----------------------------------------
   twx_dec_t dec;
   twx_faddr_t faddr;
   twx_state_t state_q;
   twx_state_t state_d;
   logic [`TWX_PTR_W-1:0] table_pointer_q; // [RULE1]
   logic [`TWX_PTR_W-1:0] ptr_pre;
   logic [1:0] ptr_mode_q;
   logic [7:0] latch_q;
   logic skip_two_q;
   logic exec;
   logic tst_zero;

   twx_decode u_decode (
      .i_word(i_instr),
      .o_dec(dec)
   );

   twx_faddr u_faddr (
      .i_access_bit(dec.access_bit),
      .i_ext_enable(i_ext_enable),
      .i_operand(dec.operand),
      .i_bank_select(i_bank_select),
      .o_faddr(faddr)
   );

   assign exec = i_instr_valid && (state_q == TWX_ST_EXEC);
   assign tst_zero = (i_file_data == 8'h00);
   assign o_file_addr = faddr;
   assign o_file_read = exec && dec.is_test_skip_zero_op && (i_qphase == `TWX_Q2); // [RULE11]
   assign o_busy = (state_q != TWX_ST_EXEC);
   assign o_fetch_hold = (state_q == TWX_ST_TBLWT2);
   assign o_flush = (state_q == TWX_ST_FLUSH1) || (state_q == TWX_ST_FLUSH2); // [RULE6]
   assign o_table_pointer = table_pointer_q;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      if (i_qphase == `TWX_Q4) begin
         unique case (state_q)
            TWX_ST_EXEC: begin
               if (exec && dec.is_table_write_op) begin
                  state_d = TWX_ST_TBLWT2; // [RULE5]
               end else if (exec && dec.is_test_skip_zero_op && tst_zero) begin
                  state_d = TWX_ST_FLUSH1; // [RULE6]
               end
            end
            TWX_ST_TBLWT2: begin
               state_d = TWX_ST_EXEC; // [RULE5]
            end
            TWX_ST_FLUSH1: begin
               state_d = skip_two_q ? TWX_ST_FLUSH2 : TWX_ST_EXEC; // [RULE7]
            end
            TWX_ST_FLUSH2: begin
               state_d = TWX_ST_EXEC; // [RULE7]
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         state_q <= TWX_ST_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         skip_two_q <= 1'b0;
      end else if (exec && dec.is_test_skip_zero_op && (i_qphase == `TWX_Q4)) begin
         skip_two_q <= i_next_two_word; // [RULE7]
      end
   end

   // ----------------------------------------
   // Table write
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         ptr_mode_q <= `TWX_NN_NONE;
      end else if (exec && dec.is_table_write_op && (i_qphase == `TWX_Q4)) begin
         ptr_mode_q <= dec.ptr_mode; // [RULE4]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         latch_q <= 8'h00;
      end else if ((state_q == TWX_ST_TBLWT2) && (i_qphase == `TWX_Q2)) begin
         latch_q <= i_table_latch; // [RULE5]
      end
   end

   assign ptr_pre = (ptr_mode_q == `TWX_NN_PREINC) ?
      table_pointer_q + `TWX_PTR_W'(1) : table_pointer_q; // [RULE3]

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         table_pointer_q <= '0;
      end else if ((state_q == TWX_ST_TBLWT2) && (i_qphase == `TWX_Q4)) begin
         unique case (ptr_mode_q)
            `TWX_NN_NONE: table_pointer_q <= table_pointer_q; // [RULE3]
            `TWX_NN_POSTINC: table_pointer_q <= table_pointer_q + `TWX_PTR_W'(1); // [RULE3]
            `TWX_NN_POSTDEC: table_pointer_q <= table_pointer_q - `TWX_PTR_W'(1); // [RULE3]
            `TWX_NN_PREINC: table_pointer_q <= ptr_pre; // [RULE3]
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_hold_we <= 1'b0;
         o_hold_addr <= '0;
         o_hold_data <= 8'h00;
         o_hold_byte_high <= 1'b0;
      end else begin
         o_hold_we <= (state_q == TWX_ST_TBLWT2) && (i_qphase == `TWX_Q4); // [RULE5]
         if ((state_q == TWX_ST_TBLWT2) && (i_qphase == `TWX_Q4)) begin
            o_hold_addr <= ptr_pre;
            o_hold_data <= latch_q; // [RULE5]
            o_hold_byte_high <= ptr_pre[0]; // [RULE2]
         end
      end
   end

   // ----------------------------------------
   // Xor literal
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_working_reg <= 8'h00;
         o_negative_flag <= 1'b0;
         o_zero_flag <= 1'b0;
      end else if (exec && dec.is_xor_literal_op && (i_qphase == `TWX_Q4)) begin
         o_working_reg <= o_working_reg ^ dec.operand; // [RULE12] [RULE14]
         o_negative_flag <= o_working_reg[7] ^ dec.operand[7]; // [RULE12]
         o_zero_flag <= ((o_working_reg ^ dec.operand) == 8'h00); // [RULE12]
      end
   end
endmodule // twx_core

// >>> src/twx_params.svh
// Constants for the table write, test-skip and xor-literal execution block.
`ifndef TWX_PARAMS_SVH
`define TWX_PARAMS_SVH
`define TWX_PTR_W 21
`define TWX_TABLE_WRITE_OP_HI 12'h000
`define TWX_TABLE_WRITE_OP_TAG 2'h3
`define TWX_TEST_SKIP_ZERO_OP_HI 7'h33
`define TWX_XOR_LITERAL_OP_HI 8'h0a
`define TWX_ILO_LIMIT 8'h5f
`define TWX_NN_NONE 2'h0
`define TWX_NN_POSTINC 2'h1
`define TWX_NN_POSTDEC 2'h2
`define TWX_NN_PREINC 2'h3
`define TWX_Q1 2'h0
`define TWX_Q2 2'h1
`define TWX_Q3 2'h2
`define TWX_Q4 2'h3
`endif

// >>> src/twx_pkg.sv
// Types for the table write, test-skip and xor-literal execution block.
package twx_pkg;
   typedef enum logic [1:0] {TWX_ST_EXEC, TWX_ST_TBLWT2, TWX_ST_FLUSH1, TWX_ST_FLUSH2} twx_state_t;
   typedef enum logic [1:0] {TWX_AM_ACCESS, TWX_AM_BANKED, TWX_AM_INDEXED} twx_amode_t;
   typedef struct packed {
      twx_amode_t mode;
      logic [3:0] bank;
      logic [7:0] offset;
   } twx_faddr_t;
   typedef struct packed {
      logic is_table_write_op;
      logic is_test_skip_zero_op;
      logic is_xor_literal_op;
      logic [1:0] ptr_mode;
      logic access_bit;
      logic [7:0] operand;
   } twx_dec_t;
endpackage

// >>> src/twx_decode.sv
// Instruction word decoder.
`timescale 1ns/100ps
`include "twx_params.svh"
module twx_decode (
   input wire logic [15:0] i_word,
   output twx_pkg::twx_dec_t o_dec
);
   import twx_pkg::*;
   always_comb begin
      o_dec = '0;
      o_dec.is_table_write_op = (i_word[15:4] == `TWX_TABLE_WRITE_OP_HI) &&
         (i_word[3:2] == `TWX_TABLE_WRITE_OP_TAG); // [RULE4]
      o_dec.is_test_skip_zero_op = (i_word[15:9] == `TWX_TEST_SKIP_ZERO_OP_HI); // [RULE8]
      o_dec.is_xor_literal_op = (i_word[15:8] == `TWX_XOR_LITERAL_OP_HI); // [RULE13]
      o_dec.ptr_mode = i_word[1:0]; // [RULE4]
      o_dec.access_bit = i_word[8];
      o_dec.operand = i_word[7:0];
   end
endmodule // twx_decode

// >>> src/twx_faddr.sv
// File operand address mode selection.
`timescale 1ns/100ps
`include "twx_params.svh"
module twx_faddr (
   input wire logic i_access_bit,
   input wire logic i_ext_enable,
   input wire logic [7:0] i_operand,
   input wire logic [3:0] i_bank_select,
   output twx_pkg::twx_faddr_t o_faddr
);
   import twx_pkg::*;
   always_comb begin
      o_faddr.offset = i_operand;
      o_faddr.bank = i_bank_select;
      if (i_access_bit) begin
         o_faddr.mode = TWX_AM_BANKED; // [RULE9]
      end else if (i_ext_enable && (i_operand <= `TWX_ILO_LIMIT)) begin
         o_faddr.mode = TWX_AM_INDEXED; // [RULE10]
      end else begin
         o_faddr.mode = TWX_AM_ACCESS; // [RULE9]
      end
   end
endmodule // twx_faddr

// >>> test/twx_pipe.sv
// Partner model: Q phase sequencer and file register array.
`timescale 1ns/100ps
module twx_pipe (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [7:0] i_offset,
   output logic [1:0] o_qphase,
   output logic [7:0] o_file_data
);
   always_ff @(posedge i_clock) begin
      if (!i_rstn) o_qphase <= 2'h0;
      else o_qphase <= o_qphase + 2'h1;
   end
   // Registers whose offset has bit 1 clear read as zero.
   assign o_file_data = i_offset[1] ? i_offset : 8'h00;
endmodule // twx_pipe

// >>> test/twx_chk.sv
// Concurrent checks on the execution block ports.
`timescale 1ns/100ps
module twx_chk (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [1:0] i_qphase,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic i_next_two_word,
   input wire logic [7:0] i_file_data,
   input wire logic o_busy,
   input wire logic o_flush,
   input wire logic o_fetch_hold,
   input wire logic o_hold_we,
   input wire logic [7:0] o_working_reg,
   input wire logic o_negative_flag,
   input wire logic o_zero_flag
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   wire g = i_instr_valid && !o_busy && i_qphase == 2'h3;
   wire x = g && i_instr[15:8] == 8'h0a;
   wire t = g && i_instr[15:9] == 7'h33;
   wire z = t && i_file_data == 8'h00;
   a_xor_value: assert property (x |=>
      o_working_reg == ($past(o_working_reg) ^ $past(i_instr[7:0]))) else $error("xor");
   a_xor_flags: assert property (x |=>
      o_zero_flag == (o_working_reg == 8'h00) && o_negative_flag == o_working_reg[7]) else $error("nz");
   a_skip_short: assert property (z && !i_next_two_word |=>
      o_flush [*4] ##1 !o_flush) else $error("skip");
   a_skip_long: assert property (z && i_next_two_word |=>
      o_flush [*8] ##1 !o_flush) else $error("skip2");
   a_skip_none: assert property (t && !z |=> !o_flush && !o_busy) else $error("noskip");
   a_skip_flags: assert property (t |=> $stable(o_zero_flag) && $stable(o_negative_flag))
      else $error("flags");
   a_table_write_op_len: assert property (g && i_instr[15:2] == 14'h3 |=>
      o_fetch_hold [*4] ##1 o_hold_we) else $error("table_write_op");
   a_hold_pulse: assert property (o_hold_we |=> !o_hold_we) else $error("pulse");
endmodule // twx_chk
bind twx_core twx_chk i_chk (.*);

// >>> test/twx_core_tb.sv
// Self-checking bench for the execution block.
`timescale 1ns/100ps
module twx_core_tb;
   import twx_pkg::*;
   logic i_clock = 0, i_rstn = 0, i_instr_valid = 0, i_next_two_word = 0, i_ext_enable = 0;
   logic o_file_read, o_fetch_hold, o_flush, o_busy, o_hold_we, o_hold_byte_high, sk;
   logic o_negative_flag, o_zero_flag;
   logic [1:0] i_qphase, m;
   logic [15:0] i_instr = '0;
   logic [3:0] i_bank_select = '0;
   logic [7:0] i_file_data, i_table_latch = '0, o_working_reg, o_hold_data, w = '0, k, f;
   logic [20:0] o_table_pointer, o_hold_addr, p = '0, a;
   logic [31:0] s = 32'h4ef3;
   twx_faddr_t o_file_addr;
   int fail_count = 0, check_count = 0;
   twx_core i_dut (.*);
   twx_pipe i_pipe (.i_clock(i_clock), .i_rstn(i_rstn), .i_offset(o_file_addr.offset),
      .o_qphase(i_qphase), .o_file_data(i_file_data));
   initial forever #12.5 i_clock = ~i_clock;
   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic [1:0] nz(input logic [7:0] r);
      return {r[7], r == 8'h00};
   endfunction
   function automatic logic [1:0] em(input logic b, e, input logic [7:0] v);
      return b ? 2'h1 : (e && v <= 8'h5f) ? 2'h2 : 2'h0;
   endfunction
   task chk(input logic [20:0] v, e);
      check_count++;
      if (v !== e) begin
         fail_count++;
         $display("MISMATCH %0t %h %h", $time, v, e);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task issue(input logic [15:0] v);
      i_instr <= v;
      i_instr_valid <= 1'h1;
      @(posedge i_clock);
      #1;
   endtask
   task fin(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge i_clock);
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'h1;
      #1;
      for (int i = 0; i < 24; i++) begin
         k = (i == 5) ? w : 8'(rnd());
         issue({8'h0a, k});
         fin(3);
         w = w ^ k;
         chk(o_working_reg, w);
         chk({o_negative_flag, o_zero_flag}, nz(w));
      end
      for (int i = 0; i < 8; i++) begin
         m = 2'(i + 2);
         k = 8'(rnd());
         i_table_latch <= k;
         issue({14'h3, m});
         fin(3);
         issue(16'h0aff);
         fin(3);
         a = p + 21'(m == 2'h3);
         if (m[0]) p = p + 21'h1;
         else if (m[1]) p = p - 21'h1;
         chk(o_hold_we, 1'h1);
         chk(o_hold_addr, a);
         chk(o_hold_byte_high, a[0]);
         chk(o_hold_data, k);
         chk(o_table_pointer, p);
         chk(o_working_reg, w);
      end
      for (int i = 0; i < 16; i++) begin
         k = 8'(rnd());
         f = {k[7:2], i[2], k[0]};
         i_ext_enable <= i[1];
         i_bank_select <= k[3:0];
         i_next_two_word <= i[3];
         issue({7'h33, i[0], f});
         chk(o_file_read, 1'h1);
         chk(o_file_addr.mode, em(i[0], i[1], f));
         if (i[0]) chk(o_file_addr.bank, k[3:0]);
         fin(3);
         sk = !f[1];
         chk(o_flush, sk);
         if (sk) begin
            fin(i[3] ? 7 : 3);
            chk(o_flush, 1'h1);
            fin(1);
         end
         chk(o_busy, 1'h0);
         chk({o_negative_flag, o_zero_flag}, nz(w));
      end
      complete_run;
   end
endmodule // twx_core_tb
